// File: shared/havs_pkg.sv
// Constants and types for the audio and video-infoframe status register bank.
// Functional notes
// R1: Word-length codes: 0000 unspecified, 0100 16, 0011 17, 0010 18, 0001 19, 0101 20 bits.
// R2: Long-range codes: 1000 unspecified, 1100 20, 1011 21, 1010 22, 1001 23, 1101 24 bits.
// R3: A 20-bit audio cycle time stamp is held and its bits 19 to 12 read at offset 0x7B.
// R4: Time-stamp bits 11 to 4 read at 0x7C and bits 3 to 0 read in the upper nibble of 0x7D.
// R5: A 20-bit regeneration divisor is held and its bits 19 to 16 read in the lower nibble of 0x7D.
// R6: Divisor bits 15 to 8 read at 0x7E and bits 7 to 0 read at 0x7F.
// R7: Bits 6 to 5 at 0x81 give the colour format: 00 RGB, 01 YCbCr 4:2:2, 10 YCbCr 4:4:4.
// R8: Bit 4 at 0x81 reads 1 when active-format data is valid and 0 when absent.
// R9: Bits 3 to 2 at 0x81 give bar validity: 00 none, 01 horizontal, 10 vertical, 11 both.
// R10: Bits 1 to 0 at 0x81 give scan data: 00 none, 01 overscanned, 10 underscanned.
// R11: Bits 7 to 6 at 0x82 give colorimetry: 00 none, 01 SMPTE 170M, 10 ITU709.
// R12: Bits 5 to 4 at 0x82 give the picture aspect ratio: 00 none, 01 4:3, 10 16:9.
// R13: Every register of the bank is read-only and host writes change nothing.
// R14: Each field is refreshed whenever a decoded packet of its own type arrives from the link.
package havs_pkg;

  localparam int unsigned HAVS_ADR_W  = 10;
  localparam int unsigned HAVS_DAT_W  = 32;
  localparam int unsigned HAVS_STAMP_W = 20;

  // Register indices; the byte address on the bus is four times the index.
  localparam logic [7:0] HAVS_IDX_WORD_LEN    = 8'h62;
  localparam logic [7:0] HAVS_IDX_WORD_BITS   = 8'h63;
  localparam logic [7:0] HAVS_IDX_SEEN        = 8'h64;
  localparam logic [7:0] HAVS_IDX_STAMP_HIGH  = 8'h7B;
  localparam logic [7:0] HAVS_IDX_STAMP_MID   = 8'h7C;
  localparam logic [7:0] HAVS_IDX_STAMP_DIV   = 8'h7D;
  localparam logic [7:0] HAVS_IDX_DIV_MID     = 8'h7E;
  localparam logic [7:0] HAVS_IDX_DIV_LOW     = 8'h7F;
  localparam logic [7:0] HAVS_IDX_AVI_VERSION = 8'h80;
  localparam logic [7:0] HAVS_IDX_AVI_FORMAT  = 8'h81;
  localparam logic [7:0] HAVS_IDX_AVI_COLOUR  = 8'h82;

  // Field positions.
  localparam int unsigned HAVS_WL_LSB   = 0;
  localparam int unsigned HAVS_FMT_LSB  = 5;
  localparam int unsigned HAVS_AFI_BIT  = 4;
  localparam int unsigned HAVS_BAR_LSB  = 2;
  localparam int unsigned HAVS_SCAN_LSB = 0;
  localparam int unsigned HAVS_COLM_LSB = 6;
  localparam int unsigned HAVS_ASP_LSB  = 4;

  // Reset values of the held fields.
  localparam logic [3:0]  HAVS_WL_RST    = 4'h0;
  localparam logic [19:0] HAVS_STAMP_RST = 20'h00000;
  localparam logic [7:0]  HAVS_BYTE_RST  = 8'h00;
  localparam logic [4:0]  HAVS_BITS_RST  = 5'h00;

  // Word-length codes.
  localparam logic [3:0] HAVS_WL_NONE_S = 4'h0;
  localparam logic [3:0] HAVS_WL_16     = 4'h4;
  localparam logic [3:0] HAVS_WL_17     = 4'h3;
  localparam logic [3:0] HAVS_WL_18     = 4'h2;
  localparam logic [3:0] HAVS_WL_19     = 4'h1;
  localparam logic [3:0] HAVS_WL_20S    = 4'h5;
  localparam logic [3:0] HAVS_WL_NONE_L = 4'h8;
  localparam logic [3:0] HAVS_WL_20L    = 4'hC;
  localparam logic [3:0] HAVS_WL_21     = 4'hB;
  localparam logic [3:0] HAVS_WL_22     = 4'hA;
  localparam logic [3:0] HAVS_WL_23     = 4'h9;
  localparam logic [3:0] HAVS_WL_24     = 4'hD;

  typedef enum logic [1:0]
  {
    HAVS_FMT_RGB = 2'h0,
    HAVS_FMT_422 = 2'h1,
    HAVS_FMT_444 = 2'h2
  } havs_fmt_t;

  typedef enum logic [0:0]
  {
    HAVS_BUS_IDLE = 1'b0,
    HAVS_BUS_ACK  = 1'b1
  } havs_bus_state_t;

endpackage

// File: shared/havs_cap_if.sv
// Interface carrying decoded packets into the field store and held fields back out.
interface havs_cap_if;
  logic        acr_load;
  logic [19:0] acr_stamp;
  logic [19:0] acr_divisor;
  logic        acs_load;
  logic [3:0]  acs_word_len;
  logic        avi_load;
  logic [7:0]  avi_version;
  logic [7:0]  avi_format;
  logic [7:0]  avi_colour;
  logic [19:0] held_stamp;
  logic [19:0] held_divisor;
  logic [3:0]  held_word_len;
  logic [7:0]  held_version;
  logic [7:0]  held_format;
  logic [7:0]  held_colour;
  logic [2:0]  held_seen;

  modport feeder
  (
    output acr_load, acr_stamp, acr_divisor, acs_load, acs_word_len,
    output avi_load, avi_version, avi_format, avi_colour,
    input  held_stamp, held_divisor, held_word_len, held_version, held_format,
    input  held_colour, held_seen
  );

  modport store
  (
    input  acr_load, acr_stamp, acr_divisor, acs_load, acs_word_len,
    input  avi_load, avi_version, avi_format, avi_colour,
    output held_stamp, held_divisor, held_word_len, held_version, held_format,
    output held_colour, held_seen
  );
endinterface

// File: verilog/havs_field_store.sv
// Field store holding the most recent decoded packet contents.
module havs_field_store
  import havs_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  havs_cap_if.store cap
);

  logic [19:0] stamp_reg;
  logic [19:0] divisor_reg;
  logic [3:0]  word_len_reg;
  logic [7:0]  version_reg;
  logic [7:0]  format_reg;
  logic [7:0]  colour_reg;
  logic [2:0]  seen_reg;

  // Stamp and divisor load in the same edge so a reader never sees a mixed pair.
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      stamp_reg   <= HAVS_STAMP_RST;
      divisor_reg <= HAVS_STAMP_RST;
    end
    else if (cap.acr_load) // R14
    begin
      stamp_reg   <= cap.acr_stamp; // R3
      divisor_reg <= cap.acr_divisor; // R5
    end
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      word_len_reg <= HAVS_WL_RST;
    else if (cap.acs_load) // R14
      word_len_reg <= cap.acs_word_len;
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      version_reg <= HAVS_BYTE_RST;
      format_reg  <= HAVS_BYTE_RST;
      colour_reg  <= HAVS_BYTE_RST;
    end
    else if (cap.avi_load) // R14
    begin
      version_reg <= cap.avi_version;
      format_reg  <= cap.avi_format;
      colour_reg  <= cap.avi_colour;
    end
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      seen_reg <= 3'h0;
    else
      seen_reg <= seen_reg | {cap.avi_load, cap.acs_load, cap.acr_load};
  end

  assign cap.held_stamp    = stamp_reg;
  assign cap.held_divisor  = divisor_reg;
  assign cap.held_word_len = word_len_reg;
  assign cap.held_version  = version_reg;
  assign cap.held_format   = format_reg;
  assign cap.held_colour   = colour_reg;
  assign cap.held_seen     = seen_reg;

endmodule

// File: verilog/havs_status_regs.sv
// Read-only audio and video-infoframe status bank with a classic Wishbone slave.
//
// The Wishbone interface to the registers was chosen for this implementation.
module havs_status_regs
  import havs_pkg::*;
(
  input  wire logic                  clk,
  input  wire logic                  sys_rst,
  input  wire logic                  wb_cyc_i,
  input  wire logic                  wb_stb_i,
  input  wire logic                  wb_we_i,
  input  wire logic [HAVS_ADR_W-1:0] wb_adr_i,
  input  wire logic [3:0]            wb_sel_i,
  input  wire logic [HAVS_DAT_W-1:0] wb_dat_i,
  output logic      [HAVS_DAT_W-1:0] wb_dat_o,
  output logic                       wb_ack_o,
  input  wire logic                  acr_pkt_valid,
  input  wire logic [19:0]           acr_pkt_stamp,
  input  wire logic [19:0]           acr_pkt_divisor,
  input  wire logic                  acs_pkt_valid,
  input  wire logic [3:0]            acs_pkt_word_len,
  input  wire logic                  avi_pkt_valid,
  input  wire logic [7:0]            avi_pkt_version,
  input  wire logic [7:0]            avi_pkt_byte1,
  input  wire logic [7:0]            avi_pkt_byte2,
  output logic      [19:0]           regen_stamp,
  output logic      [19:0]           regen_divisor,
  output logic      [4:0]            audio_word_bits,
  output logic      [1:0]            video_colour_format
);

  ////////////////////////////////////////////////////////////////////////////////
  // Field store.

  havs_cap_if cap ();

  // Packets come from the decoder on this same clock, so no synchroniser is needed.
  assign cap.acr_load     = acr_pkt_valid; // R14
  assign cap.acr_stamp    = acr_pkt_stamp;
  assign cap.acr_divisor  = acr_pkt_divisor;
  assign cap.acs_load     = acs_pkt_valid; // R14
  assign cap.acs_word_len = acs_pkt_word_len;
  assign cap.avi_load     = avi_pkt_valid; // R14
  assign cap.avi_version  = avi_pkt_version;
  assign cap.avi_format   = avi_pkt_byte1;
  assign cap.avi_colour   = avi_pkt_byte2;

  havs_field_store u_store
  (
    .clk     (clk),
    .sys_rst (sys_rst),
    .cap     (cap.store)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Word-length decode.

  function automatic logic [4:0] havs_word_bits(input logic [3:0] code);
    logic [4:0] bits;
    bits = 5'h00;
    case (code)
      HAVS_WL_16:     bits = 5'h10; // R1
      HAVS_WL_17:     bits = 5'h11; // R1
      HAVS_WL_18:     bits = 5'h12; // R1
      HAVS_WL_19:     bits = 5'h13; // R1
      HAVS_WL_20S:    bits = 5'h14; // R1
      HAVS_WL_20L:    bits = 5'h14; // R2
      HAVS_WL_21:     bits = 5'h15; // R2
      HAVS_WL_22:     bits = 5'h16; // R2
      HAVS_WL_23:     bits = 5'h17; // R2
      HAVS_WL_24:     bits = 5'h18; // R2
      HAVS_WL_NONE_S: bits = 5'h00; // R1
      HAVS_WL_NONE_L: bits = 5'h00; // R2
      default:        bits = 5'h00;
    endcase
    return bits;
  endfunction

  logic [4:0] word_bits_reg;
  logic [4:0] word_bits_next;

  // Reserved codes also report zero, the same as unspecified.
  assign word_bits_next = havs_word_bits(cap.held_word_len);

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      word_bits_reg <= HAVS_BITS_RST;
    else
      word_bits_reg <= word_bits_next;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Field views for the register map and the outputs.

  wire [7:0] word_len_byte = {4'h0, cap.held_word_len};
  wire [7:0] word_bits_byte = {3'h0, word_bits_reg};
  wire [7:0] seen_byte = {5'h00, cap.held_seen};
  wire [7:0] stamp_high_byte = cap.held_stamp[19:12]; // R3
  wire [7:0] stamp_mid_byte = cap.held_stamp[11:4]; // R4
  wire [7:0] stamp_div_byte = {cap.held_stamp[3:0], cap.held_divisor[19:16]}; // R4 R5
  wire [7:0] div_mid_byte = cap.held_divisor[15:8]; // R6
  wire [7:0] div_low_byte = cap.held_divisor[7:0]; // R6

  // Bit 7 of byte one is reserved and reads as zero.
  wire [1:0] fmt_field  = cap.held_format[HAVS_FMT_LSB+:2]; // R7
  wire       afi_field  = cap.held_format[HAVS_AFI_BIT]; // R8
  wire [1:0] bar_field  = cap.held_format[HAVS_BAR_LSB+:2]; // R9
  wire [1:0] scan_field = cap.held_format[HAVS_SCAN_LSB+:2]; // R10
  wire [1:0] colm_field = cap.held_colour[HAVS_COLM_LSB+:2]; // R11
  wire [1:0] asp_field  = cap.held_colour[HAVS_ASP_LSB+:2]; // R12

  wire [7:0] avi_format_byte = {1'b0, fmt_field, afi_field, bar_field, scan_field};
  // The low nibble carries the active-format aspect ratio from the same packet byte.
  wire [7:0] avi_colour_byte = {colm_field, asp_field, cap.held_colour[3:0]};

  ////////////////////////////////////////////////////////////////////////////////
  // Wishbone slave.

  havs_bus_state_t bus_state_reg;
  havs_bus_state_t bus_state_next;
  logic [HAVS_DAT_W-1:0] rd_data_reg;
  logic [HAVS_DAT_W-1:0] rd_data_next;

  wire       bus_req = wb_cyc_i & wb_stb_i;
  wire [7:0] reg_idx = wb_adr_i[HAVS_ADR_W-1:2];

  wire hit_word_len   = (reg_idx == HAVS_IDX_WORD_LEN);
  wire hit_word_bits  = (reg_idx == HAVS_IDX_WORD_BITS);
  wire hit_seen       = (reg_idx == HAVS_IDX_SEEN);
  wire hit_stamp_high = (reg_idx == HAVS_IDX_STAMP_HIGH);
  wire hit_stamp_mid  = (reg_idx == HAVS_IDX_STAMP_MID);
  wire hit_stamp_div  = (reg_idx == HAVS_IDX_STAMP_DIV);
  wire hit_div_mid    = (reg_idx == HAVS_IDX_DIV_MID);
  wire hit_div_low    = (reg_idx == HAVS_IDX_DIV_LOW);
  wire hit_version    = (reg_idx == HAVS_IDX_AVI_VERSION);
  wire hit_format     = (reg_idx == HAVS_IDX_AVI_FORMAT);
  wire hit_colour     = (reg_idx == HAVS_IDX_AVI_COLOUR);

  // Unmapped indices read as zero; the one-hot OR keeps the mux flat.
  wire [7:0] rd_byte =
      ({8{hit_word_len}}   & word_len_byte)   |
      ({8{hit_word_bits}}  & word_bits_byte)  |
      ({8{hit_seen}}       & seen_byte)       |
      ({8{hit_stamp_high}} & stamp_high_byte) |
      ({8{hit_stamp_mid}}  & stamp_mid_byte)  |
      ({8{hit_stamp_div}}  & stamp_div_byte)  |
      ({8{hit_div_mid}}    & div_mid_byte)    |
      ({8{hit_div_low}}    & div_low_byte)    |
      ({8{hit_version}}    & cap.held_version) |
      ({8{hit_format}}     & avi_format_byte) |
      ({8{hit_colour}}     & avi_colour_byte);

  // Writes are acknowledged so the master never hangs, and are then dropped.
  wire wr_ignored = bus_req & wb_we_i & (wb_sel_i != 4'h0); // R13

  always_comb
  begin
    bus_state_next = HAVS_BUS_IDLE;
    rd_data_next   = rd_data_reg;
    case (bus_state_reg)
      HAVS_BUS_IDLE:
      begin
        if (bus_req)
        begin
          bus_state_next = HAVS_BUS_ACK;
          rd_data_next   = wb_we_i ? {HAVS_DAT_W{1'b0}} : {24'h000000, rd_byte}; // R13
        end
      end
      HAVS_BUS_ACK:
      begin
        bus_state_next = HAVS_BUS_IDLE;
      end
      default:
      begin
        bus_state_next = HAVS_BUS_IDLE;
      end
    endcase
    if (wr_ignored)
      rd_data_next = {HAVS_DAT_W{1'b0}};
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      bus_state_reg <= HAVS_BUS_IDLE;
      rd_data_reg   <= {HAVS_DAT_W{1'b0}};
    end
    else
    begin
      bus_state_reg <= bus_state_next;
      rd_data_reg   <= rd_data_next;
    end
  end

  assign wb_ack_o = (bus_state_reg == HAVS_BUS_ACK);
  assign wb_dat_o = rd_data_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs toward the audio clock regenerator and the video path.

  assign regen_stamp         = cap.held_stamp; // R3
  assign regen_divisor       = cap.held_divisor; // R5
  assign audio_word_bits     = word_bits_reg;
  assign video_colour_format = fmt_field; // R7

endmodule

// File: verif/havs_monitor.sv
// Checker bound to the status bank, watching bus answers and packet loads.
module havs_monitor
  import havs_pkg::*;
(
  input wire logic                  clk,
  input wire logic                  sys_rst,
  input wire logic                  wb_cyc_i,
  input wire logic                  wb_stb_i,
  input wire logic                  wb_we_i,
  input wire logic [HAVS_ADR_W-1:0] wb_adr_i,
  input wire logic [HAVS_DAT_W-1:0] wb_dat_o,
  input wire logic                  wb_ack_o,
  input wire logic                  acr_pkt_valid,
  input wire logic [19:0]           acr_pkt_stamp,
  input wire logic [19:0]           acr_pkt_divisor,
  input wire logic                  acs_pkt_valid,
  input wire logic [3:0]            acs_pkt_word_len,
  input wire logic                  avi_pkt_valid,
  input wire logic [7:0]            avi_pkt_byte1,
  input wire logic [19:0]           regen_stamp,
  input wire logic [19:0]           regen_divisor,
  input wire logic [4:0]            audio_word_bits,
  input wire logic [1:0]            video_colour_format
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  property p_req_ack; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
  a_req_ack: assert property (p_req_ack) else $error("request not answered");
  property p_ack_one; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack_one: assert property (p_ack_one) else $error("ack held too long");
  property p_wr_zero; wb_ack_o && wb_we_i |-> wb_dat_o == 32'h0; endproperty
  a_wr_zero: assert property (p_wr_zero) else $error("write returned data");
  property p_rd_high;
    wb_ack_o && !wb_we_i && wb_adr_i[9:2] == 8'h7B
      |-> wb_dat_o == {24'h0, $past(regen_stamp[19:12])};
  endproperty
  a_rd_high: assert property (p_rd_high) else $error("stamp high byte wrong");
  property p_rd_split;
    wb_ack_o && !wb_we_i && wb_adr_i[9:2] == 8'h7D
      |-> wb_dat_o == {24'h0, $past(regen_stamp[3:0]), $past(regen_divisor[19:16])};
  endproperty
  a_rd_split: assert property (p_rd_split) else $error("split byte wrong");
  property p_acr_load;
    acr_pkt_valid
      |=> regen_stamp == $past(acr_pkt_stamp) && regen_divisor == $past(acr_pkt_divisor);
  endproperty
  a_acr_load: assert property (p_acr_load) else $error("regen values not loaded");
  property p_acr_hold; !acr_pkt_valid |=> $stable(regen_divisor); endproperty
  a_acr_hold: assert property (p_acr_hold) else $error("divisor changed unasked");
  property p_fmt; avi_pkt_valid |=> video_colour_format == $past(avi_pkt_byte1[6:5]); endproperty
  a_fmt: assert property (p_fmt) else $error("colour format not loaded");
  property p_wl16;
    acs_pkt_valid && acs_pkt_word_len == 4'h4 ##1 !acs_pkt_valid |=> audio_word_bits == 5'h10;
  endproperty
  a_wl16: assert property (p_wl16) else $error("code 4 not 16 bits");
  property p_wl24;
    acs_pkt_valid && acs_pkt_word_len == 4'hD ##1 !acs_pkt_valid |=> audio_word_bits == 5'h18;
  endproperty
  a_wl24: assert property (p_wl24) else $error("code D not 24 bits");

  c_read: cover property (wb_ack_o && !wb_we_i);
  c_write: cover property (wb_ack_o && wb_we_i);
  c_avi: cover property (avi_pkt_valid);
endmodule

bind havs_status_regs havs_monitor havs_monitor_inst
(
  .clk, .sys_rst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_o, .wb_ack_o,
  .acr_pkt_valid, .acr_pkt_stamp, .acr_pkt_divisor, .acs_pkt_valid, .acs_pkt_word_len,
  .avi_pkt_valid, .avi_pkt_byte1, .regen_stamp, .regen_divisor, .audio_word_bits,
  .video_colour_format
);

// File: verif/havs_link_src.sv
// Behavioural link source handing decoded packets to the status bank.
module havs_link_src
(
  input  wire logic   clk,
  output logic        acr_pkt_valid,
  output logic [19:0] acr_pkt_stamp,
  output logic [19:0] acr_pkt_divisor,
  output logic        acs_pkt_valid,
  output logic [3:0]  acs_pkt_word_len,
  output logic        avi_pkt_valid,
  output logic [7:0]  avi_pkt_version,
  output logic [7:0]  avi_pkt_byte1,
  output logic [7:0]  avi_pkt_byte2
);
  timeunit 1ns;
  timeprecision 1ps;

  initial
  begin
    {acr_pkt_valid, acs_pkt_valid, avi_pkt_valid} = 3'h0;
    {acr_pkt_stamp, acr_pkt_divisor, acs_pkt_word_len} = 44'h0;
    {avi_pkt_version, avi_pkt_byte1, avi_pkt_byte2} = 24'h0;
  end

  // Payload lines show the inverse once a packet ends, so stale data is never trusted.
  task automatic send_acr(input logic [19:0] s, input logic [19:0] n);
    @(posedge clk);
    acr_pkt_valid <= 1'h1;
    acr_pkt_stamp <= s;
    acr_pkt_divisor <= n;
    @(posedge clk);
    acr_pkt_valid <= 1'h0;
    acr_pkt_stamp <= ~s;
    acr_pkt_divisor <= ~n;
  endtask

  task automatic send_acs(input logic [3:0] w);
    @(posedge clk);
    acs_pkt_valid <= 1'h1;
    acs_pkt_word_len <= w;
    @(posedge clk);
    acs_pkt_valid <= 1'h0;
    acs_pkt_word_len <= ~w;
  endtask

  task automatic send_avi(input logic [7:0] v, input logic [7:0] b1, input logic [7:0] b2);
    @(posedge clk);
    avi_pkt_valid <= 1'h1;
    {avi_pkt_version, avi_pkt_byte1, avi_pkt_byte2} <= {v, b1, b2};
    @(posedge clk);
    avi_pkt_valid <= 1'h0;
    {avi_pkt_version, avi_pkt_byte1, avi_pkt_byte2} <= ~{v, b1, b2};
  endtask
endmodule

// File: verif/tb_top.sv
// Self-checking testbench for the audio and video-infoframe status bank.
module tb_top
  import havs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic                  clk, sys_rst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [HAVS_ADR_W-1:0] wb_adr_i;
  logic [3:0]            wb_sel_i, acs_pkt_word_len;
  logic [HAVS_DAT_W-1:0] wb_dat_i, wb_dat_o;
  logic                  acr_pkt_valid, acs_pkt_valid, avi_pkt_valid;
  logic [19:0]           acr_pkt_stamp, acr_pkt_divisor, regen_stamp, regen_divisor;
  logic [7:0]            avi_pkt_version, avi_pkt_byte1, avi_pkt_byte2;
  logic [4:0]            audio_word_bits;
  logic [1:0]            video_colour_format;
  int                    err_count, check_count;
  localparam logic [4:0] WL_BITS [16] = '{5'h00, 5'h13, 5'h12, 5'h11, 5'h10, 5'h14, 5'h00,
    5'h00, 5'h00, 5'h17, 5'h16, 5'h15, 5'h14, 5'h18, 5'h00, 5'h00};

  havs_status_regs havs_status_regs_inst
  (
    .clk, .sys_rst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
    .wb_dat_o, .wb_ack_o, .acr_pkt_valid, .acr_pkt_stamp, .acr_pkt_divisor, .acs_pkt_valid,
    .acs_pkt_word_len, .avi_pkt_valid, .avi_pkt_version, .avi_pkt_byte1, .avi_pkt_byte2,
    .regen_stamp, .regen_divisor, .audio_word_bits, .video_colour_format
  );
  havs_link_src havs_link_src_inst
  (
    .clk, .acr_pkt_valid, .acr_pkt_stamp, .acr_pkt_divisor, .acs_pkt_valid,
    .acs_pkt_word_len, .avi_pkt_valid, .avi_pkt_version, .avi_pkt_byte1, .avi_pkt_byte2
  );

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      err_count++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Write data is a pattern unlike every held value, so that any leak would show.
  task automatic bus(input logic we, input logic [7:0] idx, output logic [31:0] d);
    int n;
    n = 0;
    {wb_cyc_i, wb_stb_i, wb_we_i} <= {2'h3, we};
    wb_adr_i <= {idx, 2'h0};
    wb_dat_i <= 32'hA5A5A5A5;
    do
      @(posedge clk);
    while (wb_ack_o !== 1'h1 && ++n < 20);
    d = wb_dat_o;
    check({31'h0, wb_ack_o}, 32'h1);
    {wb_cyc_i, wb_stb_i} <= 2'h0;
    @(posedge clk);
  endtask

  task automatic rd_chk(input logic [7:0] idx, input logic [31:0] exp);
    logic [31:0] d;
    bus(1'h0, idx, d);
    check(d, exp);
  endtask

  task automatic t_word_len();
    for (int c = 0; c < 16; c++)
    begin
      havs_link_src_inst.send_acs(4'(c));
      rd_chk(8'h62, {28'h0, 4'(c)});
      rd_chk(8'h63, {27'h0, WL_BITS[c]});
      check({27'h0, audio_word_bits}, {27'h0, WL_BITS[c]});
    end
  endtask

  task automatic t_regen(input logic [19:0] s, input logic [19:0] n);
    havs_link_src_inst.send_acr(s, n);
    rd_chk(8'h7B, {24'h0, s[19:12]});
    rd_chk(8'h7C, {24'h0, s[11:4]});
    rd_chk(8'h7D, {24'h0, s[3:0], n[19:16]});
    rd_chk(8'h7E, {24'h0, n[15:8]});
    rd_chk(8'h7F, {24'h0, n[7:0]});
    check({12'h0, regen_stamp}, {12'h0, s});
    check({12'h0, regen_divisor}, {12'h0, n});
  endtask

  task automatic t_avi();
    logic [7:0] b1, b2;
    for (int i = 0; i < 12; i++)
    begin
      b1 = {1'h1, 2'(i % 3), 1'(i % 2), 2'(i % 4), 2'(i % 3)};
      b2 = {2'(i % 3), 2'((i + 1) % 3), 4'(i)};
      havs_link_src_inst.send_avi(8'(i + 2), b1, b2);
      rd_chk(8'h80, {24'h0, 8'(i + 2)});
      rd_chk(8'h81, {25'h0, b1[6:0]});
      rd_chk(8'h82, {24'h0, b2});
      check({30'h0, video_colour_format}, {30'h0, b1[6:5]});
    end
    check({12'h0, regen_divisor}, 32'h00001);
  endtask

  task automatic t_readonly();
    logic [31:0] d;
    bus(1'h1, 8'h7B, d);
    check(d, 32'h0);
    bus(1'h1, 8'h62, d);
    rd_chk(8'h7B, 32'hFF);
    rd_chk(8'h62, 32'hF);
    rd_chk(8'hFF, 32'h0);
    rd_chk(8'h64, 32'h7);
  endtask

  task automatic close_out();
    if (err_count == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    clk = 1'h0;
    forever #20 clk = ~clk;
  end

  initial
  begin
    #200us;
    err_count++;
    close_out();
  end

  initial
  begin
    err_count = 0;
    check_count = 0;
    {sys_rst, wb_cyc_i, wb_stb_i, wb_we_i} = 4'h8;
    wb_adr_i = 10'h000;
    wb_sel_i = 4'hF;
    wb_dat_i = 32'h0;
    repeat (16) @(posedge clk);
    sys_rst <= 1'h0;
    rd_chk(8'h7B, 32'h0);
    t_regen(20'hABCDE, 20'h12345);
    t_word_len();
    t_regen(20'hFFFFF, 20'h00001);
    t_avi();
    t_readonly();
    close_out();
  end
endmodule
